// ### result_shadow_pkg.sv
// Constants and carrier types for the sensor result readout block.
// Assumes nothing beyond a SystemVerilog-2012 compiler.
package result_shadow_pkg;

  // ==========================================================
  // Result widths and skip marker
  localparam int PRESS_W = 20;
  localparam int TEMP_W = 20;
  localparam int HUM_W = 16;
  localparam logic [19:0] SKIPPED_VALUE = 20'h80000;

  // ==========================================================
  // Data register addresses
  localparam logic [7:0] ADDR_PRESS_MSB = 8'hf7;
  localparam logic [7:0] ADDR_PRESS_LSB = 8'hf8;
  localparam logic [7:0] ADDR_PRESS_XLSB = 8'hf9;
  localparam logic [7:0] ADDR_TEMP_MSB = 8'hfa;
  localparam logic [7:0] ADDR_TEMP_LSB = 8'hfb;
  localparam logic [7:0] ADDR_TEMP_XLSB = 8'hfc;
  localparam logic [7:0] ADDR_HUM_MSB = 8'hfd;
  localparam logic [7:0] ADDR_HUM_LSB = 8'hfe;

  // ==========================================================
  // Reset and unmapped-read values
  localparam logic [7:0] READ_DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // One complete measurement set
  typedef struct packed {
    logic [PRESS_W-1:0] pressure;
    logic [TEMP_W-1:0] raw_temperature;
    logic [HUM_W-1:0] raw_humidity;
  } result_s;

  localparam result_s RESULT_RESET = '{pressure: SKIPPED_VALUE, raw_temperature: SKIPPED_VALUE,
                                       raw_humidity: 16'h0000};

endpackage

// ### sensor_result_shadow_readout.sv
// Result data registers with shadow stage for burst-read consistency.
// Assumes the measurement sequencer runs on clk_i and the host-facing
// serial front end (SPI or I2C decoder) runs on link_clk_i.
`timescale 1ns/1ps
`default_nettype none

module sensor_result_shadow_readout (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic meas_done_i,
  input wire result_shadow_pkg::result_s meas_result_i,
  input wire logic temp_skipped_i,
  input wire logic press_skipped_i,
  input wire logic link_clk_i,
  input wire logic i2c_mode_i,
  input wire logic chip_select_low_pin_i,
  input wire logic i2c_start_i,
  input wire logic i2c_stop_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic rd_en_i,
  output logic [7:0] rd_data_o,
  output logic burst_active_o,
  output logic shadow_pending_o
);
  import result_shadow_pkg::*;

  // ==========================================================
  // Link domain: burst tracking
  logic cs_meta_q, cs_sync_q, mode_meta_q, mode_sync_q;
  logic burst_d, burst_q;
  logic [7:0] rd_data_d, rd_data_q;
  logic req_meta_q, req_sync_q, ack_d, ack_q, xfer_req_q;
  result_s visible_q;
  result_s view_d, view_q, xfer_q;

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      mode_meta_q <= 1'b0;
      mode_sync_q <= 1'b0;
    end else begin
      cs_meta_q <= chip_select_low_pin_i;
      cs_sync_q <= cs_meta_q;
      mode_meta_q <= i2c_mode_i;
      mode_sync_q <= mode_meta_q;
    end
  end

  always_comb begin
    burst_d = burst_q;
    if (mode_sync_q) begin
      if (i2c_stop_i) begin
        burst_d = 1'b0;
      end else if (i2c_start_i) begin
        burst_d = 1'b1;
      end
    end else begin
      burst_d = !cs_sync_q;
    end
  end

  // Reads come from the link-side copy only; it moves only when a
  // handshake from the sequencer domain hands over a settled set.
  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_en_i) begin
      case (rd_addr_i)
        ADDR_PRESS_MSB: rd_data_d = view_q.pressure[19:12];
        ADDR_PRESS_LSB: rd_data_d = view_q.pressure[11:4];
        ADDR_PRESS_XLSB: rd_data_d = {view_q.pressure[3:0], 4'h0};
        ADDR_TEMP_MSB: rd_data_d = view_q.raw_temperature[19:12];
        ADDR_TEMP_LSB: rd_data_d = view_q.raw_temperature[11:4];
        ADDR_TEMP_XLSB: rd_data_d = {view_q.raw_temperature[3:0], 4'h0};
        ADDR_HUM_MSB: rd_data_d = view_q.raw_humidity[15:8];
        ADDR_HUM_LSB: rd_data_d = view_q.raw_humidity[7:0];
        default: rd_data_d = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      burst_q <= 1'b0;
      rd_data_q <= READ_DATA_RESET;
    end else begin
      burst_q <= burst_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ==========================================================
  // Link domain: copy of the visible set
  // The request toggle passes two flip-flops; the set itself is held
  // still in the sequencer domain until the acknowledge returns, so it
  // is never sampled while it moves.
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= xfer_req_q;
      req_sync_q <= req_meta_q;
    end
  end

  always_comb begin
    view_d = view_q;
    ack_d = ack_q;
    if (req_sync_q != ack_q) begin
      view_d = xfer_q;
      ack_d = req_sync_q;
    end
  end

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      view_q <= RESULT_RESET;
      ack_q <= 1'b0;
    end else begin
      view_q <= view_d;
      ack_q <= ack_d;
    end
  end

  // ==========================================================
  // Sequencer domain: visible and shadow sets
  logic burst_meta_q, burst_sync_q, burst_prev_q;
  logic xfer_req_d, xfer_dirty_d, xfer_dirty_q, ack_meta_q, ack_sync_q, visible_moved;
  result_s xfer_d;
  logic pending_d, pending_q;
  result_s visible_d, shadow_d, shadow_q, incoming;
  logic burst_end;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      burst_meta_q <= 1'b0;
      burst_sync_q <= 1'b0;
    end else begin
      burst_meta_q <= burst_q;
      burst_sync_q <= burst_meta_q;
    end
  end

  always_comb begin
    incoming = meas_result_i;
    if (temp_skipped_i) begin
      incoming.raw_temperature = SKIPPED_VALUE;
    end
    if (press_skipped_i) begin
      incoming.pressure = SKIPPED_VALUE;
    end
    burst_end = burst_prev_q && !burst_sync_q;
    visible_d = visible_q;
    shadow_d = shadow_q;
    pending_d = pending_q;
    // Results arrive whenever the sequencer finishes, host or not
    if (meas_done_i && burst_sync_q) begin
      shadow_d = incoming;
      pending_d = 1'b1;
    end else if (meas_done_i) begin
      // Newest result wins over a stale shadow at burst end
      visible_d = incoming;
      pending_d = 1'b0;
    end else if (burst_end && pending_q) begin
      visible_d = shadow_q;
      pending_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      burst_prev_q <= 1'b0;
      pending_q <= 1'b0;
      visible_q <= RESULT_RESET;
      shadow_q <= RESULT_RESET;
    end else begin
      burst_prev_q <= burst_sync_q;
      pending_q <= pending_d;
      visible_q <= visible_d;
      shadow_q <= shadow_d;
    end
  end

  // ==========================================================
  // Sequencer domain: hand-over of the visible set to the link side
  // A set that changes while a hand-over is in flight waits for the
  // acknowledge; the newest set is then sent, never a mixed one.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
    end else begin
      ack_meta_q <= ack_q;
      ack_sync_q <= ack_meta_q;
    end
  end

  always_comb begin
    visible_moved = (visible_d != visible_q);
    xfer_d = xfer_q;
    xfer_req_d = xfer_req_q;
    xfer_dirty_d = xfer_dirty_q || visible_moved;
    if ((xfer_req_q == ack_sync_q) && xfer_dirty_d) begin
      xfer_d = visible_d;
      xfer_req_d = !xfer_req_q;
      xfer_dirty_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xfer_req_q <= 1'b0;
      xfer_dirty_q <= 1'b0;
      xfer_q <= RESULT_RESET;
    end else begin
      xfer_req_q <= xfer_req_d;
      xfer_dirty_q <= xfer_dirty_d;
      xfer_q <= xfer_d;
    end
  end

  assign rd_data_o = rd_data_q;
  assign burst_active_o = burst_sync_q;
  assign shadow_pending_o = pending_q;

endmodule

`default_nettype wire

// ### result_shadow_props.sv
// Checker for shadow flag and read port timing.
// Assumes it is bound to the readout block.
`timescale 1ns/1ps
`default_nettype none
module result_shadow_props (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic meas_done_i,
  input wire logic burst_active_o,
  input wire logic shadow_pending_o,
  input wire logic link_clk_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic [7:0] rd_data_o
);
  // A result landing as the burst ends may go straight to the visible set
  a_shadow_fill: assert property (@(posedge clk_i) disable iff (!nrst_i)
    meas_done_i && burst_active_o |=> shadow_pending_o || !burst_active_o) else $error("no shadow");
  a_pend_cause: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(shadow_pending_o) |-> $past(meas_done_i)) else $error("stray pending");
  a_pend_burst: assert property (@(posedge clk_i) disable iff (!nrst_i)
    shadow_pending_o |-> burst_active_o || $past(burst_active_o)) else $error("pending idle");
  a_end_commit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(burst_active_o) |-> ##[0:2] !shadow_pending_o) else $error("no commit");
  a_low_unmapped: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
    rd_en_i && rd_addr_i < 8'hf7 |=> rd_data_o == 8'h00) else $error("low unmapped");
  a_high_unmapped: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
    rd_en_i && rd_addr_i > 8'hfe |=> rd_data_o == 8'h00) else $error("high unmapped");
  a_xlsb_zero: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
    rd_en_i && (rd_addr_i == 8'hf9 || rd_addr_i == 8'hfc) |=> rd_data_o[3:0] == 4'h0) else $error("xlsb");
  a_rd_hold: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
    !rd_en_i |=> $stable(rd_data_o)) else $error("read moved");
endmodule
bind sensor_result_shadow_readout result_shadow_props u_props (.clk_i, .nrst_i, .meas_done_i,
  .burst_active_o, .shadow_pending_o, .link_clk_i, .rd_en_i, .rd_addr_i, .rd_data_o);
`default_nettype wire

// ### result_host_model.sv
// Host model: frames bursts by chip select or start/stop, issues reads.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
`default_nettype none
module result_host_model (
  input wire logic link_clk_i,
  output logic cs_n_o = 1'b1,
  output logic start_o = 1'b0,
  output logic stop_o = 1'b0,
  output logic rd_en_o = 1'b0,
  output logic [7:0] rd_addr_o = 8'h00,
  output logic vld_o = 1'b0
);
  always @(posedge link_clk_i) vld_o <= rd_en_o;
  task frame(input logic i2c, input logic open);
    @(negedge link_clk_i);
    if (i2c) {start_o, stop_o} = {open, !open};
    else cs_n_o = !open;
    @(negedge link_clk_i);
    {start_o, stop_o} = 2'b00;
  endtask
  // Consecutive reads inside one frame keep the set consistent
  task rd(input logic [7:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge link_clk_i);
      rd_en_o = 1'b1;
      rd_addr_o = a + 8'(i);
    end
    @(negedge link_clk_i);
    rd_en_o = 1'b0;
    rd_addr_o = ~rd_addr_o;
  endtask
endmodule
`default_nettype wire

// ### sensor_result_shadow_readout_tb.sv
// Bench: burst reads with results landing mid-burst, SPI and I2C framing.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module sensor_result_shadow_readout_tb;
  import result_shadow_pkg::*;
  logic clk_i = 1'b0, link_clk_i = 1'b0, nrst_i = 1'b0, done = 1'b0, i2c = 1'b0, sk = 1'b0;
  logic cs_n, start, stop, rd_en, vld, burst, pend;
  logic [7:0] addr, rdata, exp_q[$];
  result_s res = RESULT_RESET, m0, m1;
  int err_count = 0, check_count = 0, cyc = 0;
  initial forever #25 clk_i = ~clk_i;
  initial #7 forever #15 link_clk_i = ~link_clk_i;
  result_host_model host (.link_clk_i, .cs_n_o(cs_n), .start_o(start), .stop_o(stop), .rd_en_o(rd_en),
    .rd_addr_o(addr), .vld_o(vld));
  sensor_result_shadow_readout DUT (.clk_i, .nrst_i, .meas_done_i(done), .meas_result_i(res),
    .temp_skipped_i(sk), .press_skipped_i(sk), .link_clk_i, .i2c_mode_i(i2c), .chip_select_low_pin_i(cs_n),
    .i2c_start_i(start), .i2c_stop_i(stop), .rd_addr_i(addr), .rd_en_i(rd_en), .rd_data_o(rdata),
    .burst_active_o(burst), .shadow_pending_o(pend));
  task chk(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] eb(result_s r, logic [7:0] a);
    logic [63:0] v;
    v = {r.pressure, 4'h0, r.raw_temperature, 4'h0, r.raw_humidity};
    return (a < ADDR_PRESS_MSB || a > ADDR_HUM_LSB) ? 8'h00 : v[63 - 8 * (a - ADDR_PRESS_MSB) -: 8];
  endfunction
  task rb(input logic [7:0] a, input int n, input result_s r);
    for (int i = 0; i < n; i++) exp_q.push_back(eb(r, a + 8'(i)));
    host.rd(a, n);
  endtask
  task meas(output result_s e, input logic s);
    @(negedge clk_i);
    res = result_s'(56'({$urandom(), $urandom()}));
    {done, sk} = {1'b1, s};
    e = res;
    if (s) {e.pressure, e.raw_temperature} = {SKIPPED_VALUE, SKIPPED_VALUE};
    @(negedge clk_i);
    done = 1'b0;
  endtask
  task burst_to(input logic open);
    host.frame(i2c, open);
    for (int i = 0; i < 60 && burst !== open; i++) @(negedge clk_i);
    repeat (4) @(negedge clk_i);
    chk(8'(burst), 8'(open));
  endtask
  always @(negedge link_clk_i) if (vld && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
  always @(posedge clk_i) if (++cyc > 6000) begin
    err_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h960cc590));
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    rb(8'hf6, 10, RESULT_RESET);
    meas(m0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      burst_to(1'b1);
      rb(8'hf7, 8, m0);
      // Result lands mid-burst, as with a fast free-running schedule
      meas(m1, k[0]);
      chk(8'(pend), 8'h01);
      rb(8'hf7, 5, m0);
      burst_to(1'b0);
      chk(8'(pend), 8'h00);
      rb(8'hf7, 8, m1);
      // New visible set outside a burst leaves a stale shadow behind
      meas(m0, 1'b0);
      burst_to(1'b1);
      rb(8'hf7, 8, m0);
      burst_to(1'b0);
      rb(8'hf7, 8, m0);
      i2c = 1'b1;
      // Mode pin passes two link flip-flops before framing may follow
      repeat (4) @(negedge link_clk_i);
    end
    repeat (4) @(negedge link_clk_i);
    chk(8'(exp_q.size()), 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
